// *** rtl/asmc_top.v ***
// Asynchronous serial interface with mode, baud and status registers.
// Functional notes
// RULE1 - Reset loads mode register with 01H.
// RULE2 - Power bit low resets transmit and receive logic.
// RULE3 - Enable bits select stop, receive, transmit, both.
// RULE4 - Both disabled: no transfer, pins to port.
// RULE5 - Parity field: none, zero, odd, even.
// RULE6 - Seven or eight data bits; one or two stops.
// RULE7 - Routing zero: error raises only error interrupt.
// RULE8 - Routing one: error raises completion interrupt instead.
// RULE9 - Transmit pin low when unpowered, idles high.
// RULE10 - Software enables pin output after power bit.
// RULE11 - Software stops transfers before changing mode.
// RULE12 - Software sets pin directions and latch.
// RULE13 - Start-bit framed bytes, full duplex.
// RULE14 - Dedicated baud generator times both directions.
// RULE15 - Receiver checks one stop; flags framing, parity.
// RULE16 - Unread buffer: overrun, new byte discarded.
// RULE17 - Divide value k from 8 to 31.
// RULE18 - Status resets 00H, read-only, three error flags.
// RULE19 - LSB first, parity, stops, idle high.
`timescale 1ns/1ps
`include "asmc_defs.vh"
module asmc_top #(
	parameter PRESC_BASE = 16
) (
	input wire mclk_i,
	input wire rst_i,
	input wire [15:0] addr_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	input wire serial_rx_pin_i,
	output reg serial_tx_pin_o,
	output reg serial_tx_pin_oe_o,
	output reg rx_serial_role_o,
	output reg receive_done_irq_o,
	output reg receive_error_irq_o,
	output reg tx_ready_o
);
	localparam S_IDLE = 3'h0;
	localparam S_START = 3'h1;
	localparam S_DATA = 3'h2;
	localparam S_PAR = 3'h3;
	localparam S_STOP = 3'h4;

	reg [7:0] mode_q;
	reg [7:0] baud_q;
	reg [2:0] stat_q;
	reg [7:0] rxbuf_q;
	reg rx_full_q;
	wire core_rst;
	wire power;
	wire tx_on;
	wire rx_on;
	wire [1:0] par_sel;
	wire [3:0] nbits;
	wire [4:0] k_eff;
	wire sel_mode;
	wire sel_baud;
	wire sel_data;
	wire sel_stat;

	assign power = mode_q[`ASMC_MODE_POWER];
	// Power low holds the serial logic in reset without a clock edge.
	assign core_rst = rst_i | ~power; // RULE2
	assign tx_on = power & mode_q[`ASMC_MODE_TXEN]; // RULE3
	assign rx_on = power & mode_q[`ASMC_MODE_RXEN]; // RULE3
	assign par_sel = mode_q[`ASMC_MODE_PAR_HI:`ASMC_MODE_PAR_LO];
	assign nbits = mode_q[`ASMC_MODE_CHLEN] ? 4'h8 : 4'h7; // RULE6
	// Prohibited divide values below eight run as eight.
	assign k_eff = (baud_q[4:0] < `ASMC_K_MIN) ? `ASMC_K_MIN :
		baud_q[4:0]; // RULE17
	assign sel_mode = (addr_i == `ASMC_ADDR_MODE);
	assign sel_baud = (addr_i == `ASMC_ADDR_BAUD);
	assign sel_data = (addr_i == `ASMC_ADDR_DATA);
	assign sel_stat = (addr_i == `ASMC_ADDR_STAT);

	// Control registers see only the chip reset, never the power bit.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q <= `ASMC_MODE_RESET; // RULE1
			baud_q <= `ASMC_BAUD_RESET;
			rdata_o <= 8'h00;
		end else begin
			if (wr_i && sel_mode) begin
				mode_q <= wdata_i;
			end
			if (wr_i && sel_baud) begin
				baud_q <= wdata_i & `ASMC_BAUD_MASK;
			end
			if (rd_i) begin
				if (sel_mode) begin
					rdata_o <= mode_q;
				end else if (sel_baud) begin
					rdata_o <= baud_q;
				end else if (sel_data) begin
					rdata_o <= rxbuf_q;
				end else if (sel_stat) begin
					rdata_o <= {5'h00, stat_q}; // RULE18
				end else begin
					rdata_o <= 8'h00;
				end
			end
		end
	end

	// Baud prescaler: one tick every PRESC_BASE << select cycles.
	reg [15:0] presc_q;
	reg tick_q;
	wire [15:0] presc_len;
	assign presc_len = (PRESC_BASE[15:0] << baud_q[7:6]) - 16'h0001;
	always @(posedge mclk_i or posedge core_rst) begin
		if (core_rst) begin
			presc_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (presc_q == presc_len); // RULE14
			presc_q <= (presc_q >= presc_len) ? 16'h0000 : presc_q + 16'h0001;
		end
	end

	// Transmit data buffer; the transmitter stalls it while busy.
	wire tb_ready;
	wire tb_valid;
	wire [7:0] tb_data;
	reg tb_pop;
	asmc_buf2 #(.W(8)) u_txbuf (
		.mclk_i(mclk_i),
		.rst_i(core_rst),
		.in_valid_i(wr_i && sel_data && tx_on),
		.in_ready_o(tb_ready),
		.in_data_i(wdata_i),
		.out_valid_o(tb_valid),
		.out_ready_i(tb_pop),
		.out_data_o(tb_data)
	);

	// Transmitter: start, data LSB first, parity, stop bits.
	reg [2:0] ts_q;
	reg [7:0] tsh_q;
	reg [3:0] tbit_q;
	reg [4:0] tk_q;
	reg tpar_q;
	reg tstop2_q;
	wire tbit_end;
	assign tbit_end = tick_q && (tk_q == k_eff - 5'h01);
	always @(posedge mclk_i or posedge core_rst) begin
		if (core_rst) begin
			ts_q <= S_IDLE;
			tsh_q <= 8'h00;
			tbit_q <= 4'h0;
			tk_q <= 5'h00;
			tpar_q <= 1'b0;
			tstop2_q <= 1'b0;
			tb_pop <= 1'b0;
			serial_tx_pin_o <= 1'b0; // RULE9
		end else begin
			tb_pop <= 1'b0;
			if (tick_q) begin
				tk_q <= (tk_q == k_eff - 5'h01) ? 5'h00 : tk_q + 5'h01;
			end
			case (ts_q)
			S_IDLE: begin
				serial_tx_pin_o <= 1'b1; // RULE9
				if (tb_valid && tx_on && !tb_pop) begin
					tsh_q <= tb_data;
					tb_pop <= 1'b1;
					// Dropping the line here gives the start bit a full k ticks.
					serial_tx_pin_o <= 1'b0; // RULE13
					tk_q <= 5'h00;
					tbit_q <= 4'h0;
					tstop2_q <= mode_q[`ASMC_MODE_STOPLEN];
					case (par_sel) // RULE5
					`ASMC_PAR_ODD: tpar_q <= ~(^(nbits == 4'h8 ?
						tb_data : {1'b0, tb_data[6:0]}));
					`ASMC_PAR_EVEN: tpar_q <= ^(nbits == 4'h8 ?
						tb_data : {1'b0, tb_data[6:0]});
					default: tpar_q <= 1'b0;
					endcase
					ts_q <= S_START;
				end
			end
			S_START: begin
				serial_tx_pin_o <= 1'b0; // RULE13
				if (tbit_end) begin
					ts_q <= S_DATA;
					serial_tx_pin_o <= tsh_q[0]; // RULE19
				end
			end
			S_DATA: begin
				if (tbit_end) begin
					tsh_q <= {1'b0, tsh_q[7:1]};
					tbit_q <= tbit_q + 4'h1;
					if (tbit_q == nbits - 4'h1) begin
						if (par_sel != `ASMC_PAR_NONE) begin
							ts_q <= S_PAR;
							serial_tx_pin_o <= tpar_q;
						end else begin
							ts_q <= S_STOP;
							serial_tx_pin_o <= 1'b1;
						end
					end else begin
						serial_tx_pin_o <= tsh_q[1];
					end
				end
			end
			S_PAR: begin
				if (tbit_end) begin
					ts_q <= S_STOP;
					serial_tx_pin_o <= 1'b1;
				end
			end
			S_STOP: begin
				serial_tx_pin_o <= 1'b1;
				if (tbit_end) begin
					if (tstop2_q) begin
						tstop2_q <= 1'b0; // RULE6
					end else begin
						ts_q <= S_IDLE;
					end
				end
			end
			default: ts_q <= S_IDLE;
			endcase
		end
	end

	// Receive pin: three stages; a change counts when 2 and 3 agree.
	reg rx_s1_q;
	reg rx_s2_q;
	reg rx_s3_q;
	reg rx_lvl_q;
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			rx_lvl_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_pin_i;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q) begin
				rx_lvl_q <= rx_s3_q;
			end
		end
	end

	// Receiver: samples mid-bit; only the first stop bit is checked.
	reg [2:0] rs_q;
	reg [7:0] rsh_q;
	reg [3:0] rbit_q;
	reg [4:0] rk_q;
	reg rpar_q;
	wire rsample;
	wire rpar_bad;
	wire rerr;
	wire rovr;
	assign rsample = tick_q && (rk_q == k_eff - 5'h01);
	assign rpar_bad = par_sel[1] && (rpar_q != (par_sel == `ASMC_PAR_EVEN ?
		^rsh_q : ~^rsh_q)); // RULE15
	assign rovr = rx_full_q; // RULE16
	assign rerr = rpar_bad | ~rx_lvl_q | rovr;
	always @(posedge mclk_i or posedge core_rst) begin
		if (core_rst) begin
			rs_q <= S_IDLE;
			rsh_q <= 8'h00;
			rbit_q <= 4'h0;
			rk_q <= 5'h00;
			rpar_q <= 1'b0;
			rxbuf_q <= 8'h00;
			rx_full_q <= 1'b0;
			stat_q <= `ASMC_STAT_FLAG_RESET; // RULE18
			receive_done_irq_o <= 1'b0;
			receive_error_irq_o <= 1'b0;
		end else begin
			receive_done_irq_o <= 1'b0;
			receive_error_irq_o <= 1'b0;
			// A flag raised in the read cycle survives the clear.
			if (rd_i && sel_stat) begin
				stat_q <= 3'h0;
			end
			if (rd_i && sel_data) begin
				rx_full_q <= 1'b0;
			end
			if (tick_q) begin
				rk_q <= (rk_q == k_eff - 5'h01) ? 5'h00 : rk_q + 5'h01;
			end
			case (rs_q)
			S_IDLE: begin
				if (rx_on && !rx_lvl_q) begin // RULE4
					rs_q <= S_START;
					rk_q <= {1'b0, k_eff[4:1]};
					rbit_q <= 4'h0;
					rsh_q <= 8'h00;
				end
			end
			S_START: begin
				if (rsample) begin
					rs_q <= rx_lvl_q ? S_IDLE : S_DATA;
				end
			end
			S_DATA: begin
				if (rsample) begin
					rsh_q[rbit_q[2:0]] <= rx_lvl_q; // RULE19
					rbit_q <= rbit_q + 4'h1;
					if (rbit_q == nbits - 4'h1) begin
						rs_q <= (par_sel != `ASMC_PAR_NONE) ? S_PAR : S_STOP;
					end
				end
			end
			S_PAR: begin
				if (rsample) begin
					rpar_q <= rx_lvl_q;
					rs_q <= S_STOP;
				end
			end
			S_STOP: begin
				if (rsample) begin
					rs_q <= S_IDLE;
					stat_q <= {rpar_bad, ~rx_lvl_q, rovr}; // RULE15
					if (!rovr) begin
						rxbuf_q <= rsh_q; // RULE16
						rx_full_q <= 1'b1;
					end
					if (rerr && !mode_q[`ASMC_MODE_ERRROUTE]) begin
						receive_error_irq_o <= 1'b1; // RULE7
					end else begin
						receive_done_irq_o <= 1'b1; // RULE8
					end
				end
			end
			default: rs_q <= S_IDLE;
			endcase
		end
	end

	// Pin roles follow the enables; serial role only when enabled.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			serial_tx_pin_oe_o <= 1'b0;
			rx_serial_role_o <= 1'b0;
			tx_ready_o <= 1'b0;
		end else begin
			serial_tx_pin_oe_o <= tx_on; // RULE4
			rx_serial_role_o <= rx_on; // RULE3
			tx_ready_o <= tb_ready & tx_on;
		end
	end
endmodule

// *** rtl/asmc_defs.vh ***
// Constants for the asynchronous serial mode control block.
`ifndef ASMC_DEFS_VH
`define ASMC_DEFS_VH
`define ASMC_ADDR_MODE 16'hFF90
`define ASMC_ADDR_BAUD 16'hFF91
`define ASMC_ADDR_DATA 16'hFF92
`define ASMC_ADDR_STAT 16'hFF93
`define ASMC_MODE_RESET 8'h01
`define ASMC_BAUD_RESET 8'h1F
`define ASMC_STAT_RESET 8'h00
`define ASMC_STAT_FLAG_RESET 3'h0
`define ASMC_MODE_POWER 7
`define ASMC_MODE_TXEN 6
`define ASMC_MODE_RXEN 5
`define ASMC_MODE_PAR_HI 4
`define ASMC_MODE_PAR_LO 3
`define ASMC_MODE_CHLEN 2
`define ASMC_MODE_STOPLEN 1
`define ASMC_MODE_ERRROUTE 0
`define ASMC_STAT_PARITY 2
`define ASMC_STAT_FRAMING 1
`define ASMC_STAT_OVERRUN 0
`define ASMC_BAUD_MASK 8'hDF
`define ASMC_K_MIN 5'h08
`define ASMC_PAR_NONE 2'h0
`define ASMC_PAR_ZERO 2'h1
`define ASMC_PAR_ODD 2'h2
`define ASMC_PAR_EVEN 2'h3
`endif

// *** rtl/asmc_buf2.v ***
// Two-entry valid/ready buffer for transmit data.
`timescale 1ns/1ps
module asmc_buf2 #(
	parameter W = 8
) (
	input wire mclk_i,
	input wire rst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] mem0_q;
	reg [W-1:0] mem1_q;
	reg [1:0] cnt_q;
	wire push;
	wire pop;

	// Entry 0 is always the head, so the output never needs a mux.
	assign push = in_valid_i && (cnt_q != 2'h2);
	assign pop = out_ready_i && (cnt_q != 2'h0);
	assign in_ready_o = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o = mem0_q;

	// Shift on pop; a push lands behind whatever remains.
	always @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			mem0_q <= {W{1'b0}};
			mem1_q <= {W{1'b0}};
			cnt_q <= 2'h0;
		end else begin
			if (pop) begin
				mem0_q <= mem1_q;
			end
			if (push) begin
				if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop)) begin
					mem0_q <= in_data_i;
				end else begin
					mem1_q <= in_data_i;
				end
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// *** verif/asmc_checker.sv ***
// Port-level assertions for the serial mode control block.
`timescale 1ns/1ps
`include "asmc_defs.vh"
module asmc_checker (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic serial_tx_pin_o,
	input wire logic serial_tx_pin_oe_o,
	input wire logic rx_serial_role_o,
	input wire logic receive_done_irq_o,
	input wire logic receive_error_irq_o,
	input wire logic tx_ready_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// Mode writes take two edges to reach the pins.
	wire mw = wr_i && addr_i == `ASMC_ADDR_MODE;
	chk_power_off_pins: assert property (mw && !wdata_i[7] |-> ##2
		!serial_tx_pin_o && !serial_tx_pin_oe_o && !rx_serial_role_o)
		else $error("pins active with power off");
	chk_tx_role_on: assert property (
		mw && wdata_i[7:6] == 2'h3 ##1 !wr_i |-> ##1 serial_tx_pin_oe_o)
		else $error("transmit role missing");
	chk_rx_role_on: assert property (
		mw && wdata_i[7] && wdata_i[5] ##1 !wr_i |-> ##1 rx_serial_role_o)
		else $error("receive role missing");
	chk_stop_no_role: assert property (mw && wdata_i[6:5] == 2'h0 ##1
		!wr_i |-> ##1 !serial_tx_pin_oe_o && !rx_serial_role_o && !tx_ready_o)
		else $error("pins kept in serial role");
	chk_idle_high: assert property (
		$rose(serial_tx_pin_oe_o) |-> serial_tx_pin_o)
		else $error("line not idle high");
	chk_irq_exclusive: assert property (
		!(receive_done_irq_o && receive_error_irq_o))
		else $error("both receive events at once");
	chk_irq_pulse: assert property (
		receive_done_irq_o || receive_error_irq_o |=>
		!receive_done_irq_o && !receive_error_irq_o)
		else $error("receive event longer than a cycle");
	chk_status_upper: assert property (
		rd_i && addr_i == `ASMC_ADDR_STAT |=> rdata_o[7:3] == 5'h00)
		else $error("status upper bits set");
	// Main traffic kinds seen at the ports.
	cover property (receive_done_irq_o);
	cover property (receive_error_irq_o);
	cover property ($fell(serial_tx_pin_o) && serial_tx_pin_oe_o);
endmodule
bind asmc_top asmc_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
	.addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
	.rdata_o(rdata_o), .serial_tx_pin_o(serial_tx_pin_o),
	.serial_tx_pin_oe_o(serial_tx_pin_oe_o),
	.rx_serial_role_o(rx_serial_role_o),
	.receive_done_irq_o(receive_done_irq_o),
	.receive_error_irq_o(receive_error_irq_o), .tx_ready_o(tx_ready_o));

// *** verif/asmc_partner.sv ***
// Remote serial transceiver model.
`timescale 1ns/1ps
module asmc_partner #(
	parameter BIT = 8
) (
	input wire mclk_i,
	input wire line_i,
	input wire oe_i,
	input wire [3:0] nb_i,
	output reg line_o
);
	reg [11:0] got;
	integer got_n = 0;
	initial line_o = 1'b1;
	// Sends start then nb_i bits, low bit first; line rests high after.
	task send(input [11:0] f);
		integer i;
		begin
			line_o = 1'b0;
			repeat (BIT) @(negedge mclk_i);
			for (i = 0; i < nb_i; i++) begin
				line_o = f[i];
				repeat (BIT) @(negedge mclk_i);
			end
			line_o = 1'b1;
			repeat (BIT) @(negedge mclk_i);
		end
	endtask
	// Samples at mid-bit; unsent upper bits read as ones like stops.
	always @(negedge line_i) if (oe_i) begin : rx
		integer i;
		got = 12'hFFF;
		repeat (BIT / 2) @(negedge mclk_i);
		for (i = 0; i < nb_i; i++) begin
			repeat (BIT) @(negedge mclk_i);
			got[i] = line_i;
		end
		got_n++;
	end
endmodule

// *** verif/asmc_tb_top.sv ***
// Self-checking bench for the serial mode control block.
`timescale 1ns/1ps
`include "asmc_defs.vh"
module asmc_tb_top;
	localparam BIT = 8;
	reg mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ex;
	reg [15:0] addr_i = 16'h0000;
	reg [7:0] wdata_i = 8'h00, m, v;
	reg [3:0] nb = 4'h9;
	reg [31:0] r = 32'h340D8F7B;
	wire [7:0] rdata_o;
	wire tx, oe, role, dn, er, rdy, rx;
	integer err_total = 0, n_checks = 0, dn_n = 0, er_n = 0, i, g;
	always #5 mclk_i = ~mclk_i;
	asmc_top #(.PRESC_BASE(1)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .serial_rx_pin_i(rx), .serial_tx_pin_o(tx),
		.serial_tx_pin_oe_o(oe), .rx_serial_role_o(role),
		.receive_done_irq_o(dn), .receive_error_irq_o(er), .tx_ready_o(rdy));
	asmc_partner #(.BIT(BIT)) p (.mclk_i(mclk_i), .line_i(tx), .oe_i(oe),
		.nb_i(nb), .line_o(rx));
	// Events are one-cycle pulses, counted at the falling edge, clear of
	// the rising edge that launches them.
	always @(negedge mclk_i) begin
		if (dn === 1'b1) dn_n++;
		if (er === 1'b1) er_n++;
	end
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input [11:0] s, input [11:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wreg(input [15:0] a, input [7:0] d);
		@(negedge mclk_i);
		addr_i = a;
		wdata_i = d;
		wr_i = 1'b1;
		@(negedge mclk_i);
		wr_i = 1'b0;
	endtask
	// Read data is registered, so it is taken one edge after the strobe.
	task rreg(input [15:0] a);
		@(negedge mclk_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge mclk_i);
		rd_i = 1'b0;
		@(negedge mclk_i);
		v = rdata_o;
	endtask
	function [31:0] lf(input [31:0] x);
		lf = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Frame after the start bit; stops fill the upper bits.
	function [11:0] frm(input [7:0] d, input [7:0] c, input bad);
		reg q;
		begin
			q = c[2] ? ^d : ^d[6:0];
			frm = c[2] ? {4'hF, d} : {5'h1F, d[6:0]};
			if (c[4:3] != 2'h0)
				frm[c[2] ? 8 : 7] = bad ^ (c[4] & (c[3] ~^ q));
		end
	endfunction
	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		final_report;
	end
	// Register checks, role decoding, then duplex frames and overrun.
	initial begin
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		chk({oe, tx}, 0);
		rreg(`ASMC_ADDR_MODE);
		chk(v, `ASMC_MODE_RESET);
		rreg(16'hFF9F);
		chk(v, 0);
		wreg(`ASMC_ADDR_STAT, 8'hFF);
		rreg(`ASMC_ADDR_STAT);
		chk(v, `ASMC_STAT_RESET);
		wreg(`ASMC_ADDR_BAUD, 8'hFF);
		rreg(`ASMC_ADDR_BAUD);
		chk(v, `ASMC_BAUD_MASK);
		wreg(`ASMC_ADDR_BAUD, 8'h08);
		for (i = 3; i >= 0; i--) begin
			wreg(`ASMC_ADDR_MODE, {1'b1, i[1:0], 5'h00});
			repeat (2) @(negedge mclk_i);
			chk({oe, role, tx, rdy}, {i[1:0], 1'b1, i[1]});
		end
		for (i = 0; i < 8; i++) begin
			r = lf(r);
			m = {3'h7, i[1:0], r[2:0]};
			nb = (m[2] ? 4'h9 : 4'h8) + m[1] + (m[4:3] != 2'h0);
			ex = i[2] & i[1];
			wreg(`ASMC_ADDR_MODE, m);
			dn_n = 0;
			er_n = 0;
			g = p.got_n;
			wreg(`ASMC_ADDR_DATA, r[15:8]);
			p.send(frm(r[23:16], m, i[2]));
			repeat (3 * BIT) @(negedge mclk_i);
			chk(p.got_n - g, 1);
			chk(p.got, frm(r[15:8], m, 1'b0));
			chk(er_n, ex & !m[0]);
			chk(dn_n, !ex | m[0]);
			rreg(`ASMC_ADDR_STAT);
			chk(v, {ex, 2'h0});
			rreg(`ASMC_ADDR_DATA);
			if (!ex) chk(v, m[2] ? r[23:16] : {1'b0, r[22:16]});
		end
		wreg(`ASMC_ADDR_MODE, 8'hE4);
		nb = 4'h9;
		p.send(12'hF5A);
		p.send(12'hFA5);
		rreg(`ASMC_ADDR_STAT);
		chk(v, 8'h01);
		rreg(`ASMC_ADDR_DATA);
		chk(v, 8'h5A);
		// Three bytes back to back fill the buffer behind the shifter.
		g = p.got_n;
		wreg(`ASMC_ADDR_DATA, 8'h3C);
		wreg(`ASMC_ADDR_DATA, 8'h96);
		wreg(`ASMC_ADDR_DATA, 8'hC3);
		repeat (2) @(negedge mclk_i);
		chk(rdy, 0);
		repeat (32 * BIT) @(negedge mclk_i);
		chk(p.got_n - g, 3);
		chk(p.got, frm(8'hC3, 8'hE4, 1'b0));
		wreg(`ASMC_ADDR_MODE, 8'h80);
		wreg(`ASMC_ADDR_MODE, 8'h00);
		repeat (2) @(negedge mclk_i);
		chk({tx, oe, role, rdy}, 0);
		final_report;
	end
endmodule
